// file: design/bp_router_pkg.sv
// Behaviour
// (R1) reference select: 0 on-board, -1 backplane
// (R2) backplane reference steers the sample PLL input
// (R3) routed trigger stops triggering the board itself
// (R4) output edge rises, falls by acquisition stop
// (R5) output codes 0 none, 1-6 lines, 9 star
// (R6) output capability bitfield, low 16 bits
// (R7) input capability bitfield, same weights
// (R8) input map bits ORed into one trigger
// (R9) empty map: internal trigger only
// (R10) no path from inputs to outputs
// (R11) line 7 shows pretrigger done, ready
// (R12) line 7 open collector, pull low or release
// (R13) detection enabled only while line 7 high
// (R14) host never routes two boards onto one line
// (R15) OR triggering needs distinct lines, six boards
// (R16) star lines only with star card present
// (R17) received trigger may jitter one sample
// (R18) routing registers independent of other settings
// (R19) all line drivers released after reset
// (R20) other boards may pull line 7 low as well
// (R21) line 7 and inputs pass two flip-flops
package bp_router_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_REF_SEL = 16'h4EAC;
	localparam logic [15:0] IDX_OUT_SEL = 16'h9D6C;
	localparam logic [15:0] IDX_OUT_CAP = 16'h9D6D;
	localparam logic [15:0] IDX_IN_MAP = 16'h9D76;
	localparam logic [15:0] IDX_IN_CAP = 16'h9D77;
	localparam logic [15:0] IDX_STATUS = 16'h9D80;
	localparam int IDX_W = 16;
	localparam int IDX_LSB = 2;

	localparam logic [31:0] REF_ONBOARD = 32'h0000_0000;
	localparam logic [31:0] REF_BACKPLANE = 32'hFFFF_FFFF;

	localparam logic [31:0] OUTPUT_ROUTE_NONE = 32'h0000_0000;
	localparam logic [31:0] OUTPUT_ROUTE_LINE_ZERO = 32'h0000_0001;
	localparam logic [31:0] OUTPUT_ROUTE_LINE_FIVE = 32'h0000_0006;
	localparam logic [31:0] OUTPUT_ROUTE_STAR = 32'h0000_0009;

	localparam logic [31:0] INPUT_SOURCE_NONE = 32'h0000_0000;
	localparam int STAR_BIT = 8;
	localparam int READY_LINE = 7;
	localparam int LINES = 8;
	localparam int CAP_W = 16;

	// lines 0..5 and star are usable; line 6 unused, line 7 internal
	localparam logic [15:0] OUT_CAP_DEFAULT = 16'h013F;
	localparam logic [15:0] IN_CAP_DEFAULT = 16'h013F;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic star;
		logic [7:0] line;
	} bp_lines_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [15:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] ref_sel;
		logic [31:0] out_sel;
		logic [31:0] in_map;
		bp_lines_t sync1;
		bp_lines_t sync2;
		bp_lines_t drv_level;
		bp_lines_t drv_oe;
		logic use_backplane_reference;
		logic detect_enable;
		logic self_trigger;
	} state_t;

endpackage

// file: design/backplane_trigger_refclk_router.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module backplane_trigger_refclk_router
	import bp_router_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter logic [15:0] OUT_CAP = OUT_CAP_DEFAULT,
	parameter logic [15:0] IN_CAP = IN_CAP_DEFAULT
)
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// acquisition core
	input wire logic internal_trigger,
	input wire logic pretrigger_done,
	input wire logic acquisition_running,
	output logic self_trigger,
	output logic detect_enable,
	output logic use_backplane_reference,
	// backplane trigger lines
	input wire bp_lines_t trig_in,
	output bp_lines_t trig_out,
	output bp_lines_t trig_oe
);

	if (ADDR_W < IDX_W + IDX_LSB)
	begin
		$error("ADDR_W too narrow for the register indices");
	end

	state_t s_q;
	state_t s_d;

	////////////////////////////////////////////////////////////////////
	// output code to line mask
	function automatic bp_lines_t route_mask(input logic [31:0] code);
		bp_lines_t m;
		logic [31:0] n;
		m = '0;
		n = code - OUTPUT_ROUTE_LINE_ZERO;
		if (code >= OUTPUT_ROUTE_LINE_ZERO && code <= OUTPUT_ROUTE_LINE_FIVE)
			m.line[n[2:0]] = 1'b1; // R5
		else if (code == OUTPUT_ROUTE_STAR)
			m.star = 1'b1; // R5
		// R16
		m = m & bp_lines_t'(OUT_CAP[LINES:0]);
		return m;
	endfunction

	function automatic logic [31:0] read_word(input logic [15:0] idx,
		input state_t s);
		logic [31:0] v;
		v = '0;
		if (idx == IDX_REF_SEL)
			v = s.ref_sel;
		else if (idx == IDX_OUT_SEL)
			v = s.out_sel;
		else if (idx == IDX_OUT_CAP)
			v = {16'h0000, OUT_CAP}; // R6
		else if (idx == IDX_IN_MAP)
			v = s.in_map;
		else if (idx == IDX_IN_CAP)
			v = {16'h0000, IN_CAP}; // R7
		else if (idx == IDX_STATUS)
			v = {29'h0, s.use_backplane_reference, s.drv_level != '0,
				s.detect_enable};
		return v;
	endfunction

	function automatic logic is_mapped(input logic [15:0] idx);
		return idx == IDX_REF_SEL || idx == IDX_OUT_SEL ||
			idx == IDX_OUT_CAP || idx == IDX_IN_MAP ||
			idx == IDX_IN_CAP || idx == IDX_STATUS;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	logic [15:0] ar_idx;
	logic [15:0] aw_idx_in;
	bp_lines_t route;
	bp_lines_t in_sel;
	logic routed;
	logic bus_hit;

	assign ar_idx = araddr[IDX_LSB +: IDX_W];
	assign aw_idx_in = awaddr[IDX_LSB +: IDX_W];

	always_comb
	begin
		s_d = s_q;
		route = route_mask(s_q.out_sel);
		routed = route != '0;
		in_sel = bp_lines_t'(s_q.in_map[LINES:0]) &
			bp_lines_t'(IN_CAP[LINES:0]);
		// line 7 never counts as a trigger source, it is the ready line
		in_sel.line[READY_LINE] = 1'b0;
		bus_hit = 1'b0;
		if (clk_en)
		begin
			// write address and data may arrive in either order
			if (awvalid && s_q.awready)
			begin
				s_d.aw_got = 1'b1;
				s_d.aw_idx = aw_idx_in;
			end
			if (wvalid && s_q.wready)
			begin
				s_d.w_got = 1'b1;
				s_d.wdata = wdata;
				s_d.wstrb = wstrb;
			end
			if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
			begin
				s_d.aw_got = 1'b0;
				s_d.w_got = 1'b0;
				s_d.bvalid = 1'b1;
				s_d.bresp = RESP_OKAY;
				// R18
				if (s_q.aw_idx == IDX_REF_SEL)
					s_d.ref_sel = merge(s_q.ref_sel, s_q.wdata, s_q.wstrb);
				else if (s_q.aw_idx == IDX_OUT_SEL)
					s_d.out_sel = merge(s_q.out_sel, s_q.wdata, s_q.wstrb);
				else if (s_q.aw_idx == IDX_IN_MAP)
					s_d.in_map = merge(s_q.in_map, s_q.wdata, s_q.wstrb);
				else
					s_d.bresp = RESP_SLVERR;
			end
			else if (s_q.bvalid && bready)
				s_d.bvalid = 1'b0;
			s_d.awready = !s_d.aw_got && !s_d.bvalid;
			s_d.wready = !s_d.w_got && !s_d.bvalid;

			if (arvalid && s_q.arready)
			begin
				s_d.rvalid = 1'b1;
				s_d.rdata = read_word(ar_idx, s_q);
				s_d.rresp = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_q.rvalid && rready)
				s_d.rvalid = 1'b0;
			s_d.arready = !s_d.rvalid;

			// R1 R2
			s_d.use_backplane_reference = s_q.ref_sel == REF_BACKPLANE;

			// R21: first stage feeds only the second
			s_d.sync1 = trig_in;
			s_d.sync2 = s_q.sync1;
			// R13
			s_d.detect_enable = s_q.sync2.line[READY_LINE];

			// R4: level stays only while acquiring; R10: fed by internal only
			s_d.drv_level = acquisition_running ?
				((s_q.drv_level | (internal_trigger ? route : '0)) & route) :
				'0;
			// R3 R19
			s_d.drv_oe = route;
			// R11 R12: pull low until pretrigger done, then release
			s_d.drv_oe.line[READY_LINE] = !pretrigger_done;
			s_d.drv_level.line[READY_LINE] = 1'b0;

			// R8 R9 R3; R17: the sync stages cost up to a sample of jitter
			bus_hit = (s_q.sync2 & in_sel) != '0;
			s_d.self_trigger = s_q.detect_enable &&
				((!routed && internal_trigger) || bus_hit);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.ref_sel <= REF_ONBOARD;
			s_q.out_sel <= OUTPUT_ROUTE_NONE;
			s_q.in_map <= INPUT_SOURCE_NONE;
		end
		else
			s_q <= s_d;
	end

	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign self_trigger = s_q.self_trigger;
	assign detect_enable = s_q.detect_enable;
	assign use_backplane_reference = s_q.use_backplane_reference;
	assign trig_out = s_q.drv_level;
	assign trig_oe = s_q.drv_oe;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_ref_follow;
		clk_en && aresetn |=> use_backplane_reference ==
			($past(s_q.ref_sel) == REF_BACKPLANE);
	endproperty
	a_ref_follow: assert property (p_ref_follow) // R1
		else $error("reference select not followed");

	property p_routed_no_self;
		clk_en && routed && !bus_hit |=> !self_trigger;
	endproperty
	a_routed_no_self: assert property (p_routed_no_self) // R3
		else $error("routed trigger still fired the board");

	property p_drop_on_stop;
		clk_en && !acquisition_running |=> trig_out == '0;
	endproperty
	a_drop_on_stop: assert property (p_drop_on_stop) // R4
		else $error("output line high after acquisition stop");

	property p_route_decode;
		clk_en && aresetn |=> trig_oe.star ==
			($past(s_q.out_sel) == OUTPUT_ROUTE_STAR && OUT_CAP[STAR_BIT]) &&
			trig_oe.line[5:0] == (OUT_CAP[5:0] &
			(($past(s_q.out_sel) >= OUTPUT_ROUTE_LINE_ZERO &&
			$past(s_q.out_sel) <= OUTPUT_ROUTE_LINE_FIVE) ?
			6'(32'h1 << ($past(s_q.out_sel) - OUTPUT_ROUTE_LINE_ZERO)) :
			6'h00));
	endproperty
	a_route_decode: assert property (p_route_decode) // R5
		else $error("output code decoded wrongly");

	property p_out_cap;
		clk_en && arvalid && arready && ar_idx == IDX_OUT_CAP |=>
			rvalid && rdata == {16'h0000, OUT_CAP};
	endproperty
	a_out_cap: assert property (p_out_cap) // R6
		else $error("output capability read wrong");

	property p_in_cap;
		clk_en && arvalid && arready && ar_idx == IDX_IN_CAP |=>
			rvalid && rdata == {16'h0000, IN_CAP};
	endproperty
	a_in_cap: assert property (p_in_cap) // R7
		else $error("input capability read wrong");

	property p_empty_map;
		clk_en && s_q.in_map == INPUT_SOURCE_NONE && !internal_trigger |=>
			!self_trigger;
	endproperty
	a_empty_map: assert property (p_empty_map) // R9
		else $error("fired from bus with empty map");

	property p_no_reroute;
		(trig_out.line[5:0] != '0 || trig_out.star) |->
			(trig_out & ~trig_oe) == '0;
	endproperty
	a_no_reroute: assert property (p_no_reroute) // R10
		else $error("line level high while not driven");

	property p_ready_line;
		clk_en && aresetn |=>
			trig_oe.line[READY_LINE] == !$past(pretrigger_done) &&
			!trig_out.line[READY_LINE];
	endproperty
	a_ready_line: assert property (p_ready_line) // R12
		else $error("ready line not open collector");

	property p_sync_detect;
		(clk_en && trig_in.line[READY_LINE])[*3] |=> detect_enable;
	endproperty
	a_sync_detect: assert property (p_sync_detect) // R21
		else $error("ready level not passed to detection");

	property p_reset_hiz;
		disable iff (1'b0)
		!aresetn |=> trig_oe == '0 && trig_out == '0;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) // R19
		else $error("line driven after reset");

	property p_detect_gate;
		clk_en && !detect_enable |=> !self_trigger;
	endproperty
	a_detect_gate: assert property (p_detect_gate) // R13
		else $error("fired while ready line low");

	property p_out_rise;
		clk_en && !internal_trigger |=>
			(trig_out & ~$past(trig_out)) == '0;
	endproperty
	a_out_rise: assert property (p_out_rise) // R10
		else $error("output edge without internal trigger");

	property p_ready_release;
		clk_en && aresetn && pretrigger_done |=>
			!trig_oe.line[READY_LINE];
	endproperty
	a_ready_release: assert property (p_ready_release) // R11
		else $error("ready line held low after pretrigger");

	// two sync stages plus the decision flop: the sample of jitter
	property p_bus_latency;
		clk_en && trig_in.star ##1 clk_en ##1 clk_en && detect_enable &&
			s_q.in_map[STAR_BIT] && IN_CAP[STAR_BIT] |=> self_trigger;
	endproperty
	a_bus_latency: assert property (p_bus_latency) // R17
		else $error("selected star trigger not seen in time");

	c_routed_edge: cover property ($rose(trig_out.line[1]));
	c_bus_trigger: cover property (bus_hit ##1 self_trigger);
	c_backplane_ref: cover property ($rose(use_backplane_reference));
	c_ready_rise: cover property ($rose(detect_enable));

endmodule
`default_nettype wire

// file: tb/bp_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bp_partner
	import bp_router_pkg::*;
(
	// clock
	input wire logic aclk,
	// device drivers
	input wire bp_lines_t dut_out,
	input wire bp_lines_t dut_oe,
	// other boards
	input wire bp_lines_t drv_en,
	input wire bp_lines_t drv_val,
	// resolved lines
	output bp_lines_t bus
);
	////////////////////////////////////////////////////////////////////////
	// undriven lines other than line 7 flicker: a stale level must never pass for a trigger
	logic t_q = 1'b0;
	always @(posedge aclk) t_q <= ~t_q;
	always_comb
	begin
		for (int i = 0; i < 9; i++)
			bus[i] = dut_oe[i] ? dut_out[i] : (drv_en[i] ? drv_val[i] : t_q);
		// pull-up, any board may only pull low
		bus.line[7] = !(dut_oe.line[7] || drv_en.line[7]);
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bp_router_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [17:0] awaddr = '0;
	logic [17:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic itrig = 0, pre_done = 0, acq_run = 0, clk_en = 1;
	logic [31:0] route_exp;
	logic awready, wready, bvalid, arready, rvalid;
	logic self_trigger, detect_enable, use_bp;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] x;
	bp_lines_t trig_in, trig_out, trig_oe;
	bp_lines_t drv_en = '0, drv_val = '0;
	logic [33:0] rq[$];
	int fail_count = 0, n_tests = 0, cyc = 0, st_cnt = 0;
	always #5 aclk = ~aclk;
	backplane_trigger_refclk_router uut (.aclk(aclk), .aresetn(aresetn),
		.clk_en(clk_en), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .internal_trigger(itrig),
		.pretrigger_done(pre_done), .acquisition_running(acq_run),
		.self_trigger(self_trigger), .detect_enable(detect_enable),
		.use_backplane_reference(use_bp), .trig_in(trig_in),
		.trig_out(trig_out), .trig_oe(trig_oe));
	bp_partner far (.aclk(aclk), .dut_out(trig_out), .dut_oe(trig_oe),
		.drv_en(drv_en), .drv_val(drv_val), .bus(trig_in));
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("tests %0d fails %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// flags sampled at negedge, acted on at the next rising edge
	task automatic wr(input logic [15:0] i, input logic [31:0] d,
		input logic [1:0] r);
		logic a, w, b;
		b = 0;
		awaddr <= {i, 2'h0};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!b)
		begin
			@(negedge aclk);
			a = awready;
			w = wready;
			b = bvalid;
			if (b)
				cmp("bresp", 32'(r), 32'(bresp));
			@(posedge aclk);
			if (a)
				awvalid <= 0;
			if (w)
				wvalid <= 0;
		end
		bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] d,
		input logic [1:0] r);
		logic a, v;
		v = 0;
		rq.push_back({r, d});
		araddr <= {i, 2'h0};
		arvalid <= 1;
		rready <= 1;
		while (!v)
		begin
			@(negedge aclk);
			a = arready;
			v = rvalid;
			@(posedge aclk);
			if (a)
				arvalid <= 0;
		end
		rready <= 0;
		@(posedge aclk);
	endtask
	task automatic pulse(input bp_lines_t p, input logic t, input int e);
		int s;
		s = st_cnt;
		drv_val <= p;
		itrig <= t;
		@(posedge aclk);
		drv_val <= '0;
		itrig <= 0;
		repeat (8) @(posedge aclk);
		cmp("self", 32'(e), 32'(st_cnt > s));
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk)
	begin
		cyc++;
		if (self_trigger === 1'b1)
			st_cnt++;
		if (rvalid && rready)
		begin
			x = rq.pop_front();
			cmp("rdata", x[31:0], rdata);
			cmp("rresp", 32'(x[33:32]), 32'(rresp));
		end
		if (cyc == 3000)
		begin
			fail_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(17));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(negedge aclk);
		cmp("oe", 0, 32'(trig_oe & 9'h17F));
		@(posedge aclk);
		rd(IDX_OUT_CAP, {16'h0, OUT_CAP_DEFAULT}, RESP_OKAY);
		rd(IDX_IN_CAP, {16'h0, IN_CAP_DEFAULT}, RESP_OKAY);
		rd(16'h0001, 32'h0, RESP_SLVERR);
		wr(IDX_IN_CAP, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(IDX_IN_CAP, {16'h0, IN_CAP_DEFAULT}, RESP_OKAY);
		rd(IDX_REF_SEL, REF_ONBOARD, RESP_OKAY);
		wr(IDX_REF_SEL, REF_BACKPLANE, RESP_OKAY);
		repeat (2) @(negedge aclk);
		cmp("ref", 1, 32'(use_bp));
		@(posedge aclk);
		rd(IDX_OUT_SEL, OUTPUT_ROUTE_NONE, RESP_OKAY);
		// star route assumes a star card in the rack
		for (int c = 0; c < 11; c++)
		begin
			wr(IDX_OUT_SEL, 32'(c), RESP_OKAY);
			repeat (2) @(negedge aclk);
			route_exp = (c > 0 && c < 7) ? 32'h1 << (c - 1) :
				(c == 9 ? 32'h100 : 32'h0);
			cmp("route", route_exp, 32'(trig_oe & 9'h17F));
			@(posedge aclk);
		end
		wr(IDX_OUT_SEL, 32'h2, RESP_OKAY);
		pre_done <= 1;
		acq_run <= 1;
		repeat (6) @(negedge aclk);
		cmp("det", 1, 32'(detect_enable));
		@(posedge aclk);
		pulse('0, 1, 0);
		cmp("tout", 32'h2, 32'(trig_out));
		drv_en <= 9'h13D;
		repeat (20)
		begin
			@(posedge aclk);
			drv_val <= 9'($urandom);
		end
		@(posedge aclk);
		pulse('0, 0, 0);
		cmp("tout", 32'h2, 32'(trig_out));
		acq_run <= 0;
		repeat (2) @(negedge aclk);
		cmp("tout", 0, 32'(trig_out));
		@(posedge aclk);
		wr(IDX_OUT_SEL, OUTPUT_ROUTE_NONE, RESP_OKAY);
		wr(IDX_IN_MAP, 32'h10C, RESP_OKAY);
		pulse(9'h004, 0, 1);
		pulse(9'h008, 0, 1);
		pulse(9'h100, 0, 1);
		pulse(9'h001, 0, 0);
		drv_en <= 9'h1BD;
		repeat (6) @(negedge aclk);
		cmp("det", 0, 32'(detect_enable));
		@(posedge aclk);
		pulse(9'h004, 0, 0);
		drv_en <= 9'h13D;
		wr(IDX_IN_MAP, INPUT_SOURCE_NONE, RESP_OKAY);
		repeat (6) @(posedge aclk);
		pulse(9'h10C, 0, 0);
		// frozen clock enable swallows the internal trigger
		clk_en <= 0;
		pulse('0, 1, 0);
		clk_en <= 1;
		pulse('0, 1, 1);
		complete_run();
	end
endmodule
`default_nettype wire
